// file: rct_pkg.sv
// Constants and types shared by the reload countdown timer block.
// Assumes a byte-wide register port and a 200 MHz system clock.
// Contract
// RL1 - Start event loads second timer with 16-bit reload from high and low bytes.
// RL2 - Reload byte writes never disturb a running count; used at next start.
// RL3 - Third timer reload is 16 bits as readable, writable high and low bytes.
// RL4 - Live second timer count readable as read-only high and low bytes.
// RL5 - Host avoids reading live count bytes while reception is in progress.
// RL6 - Stop-on-receive halts third timer after first four received bits.
// RL7 - Stop-on-receive has no effect in either oscillator-trimming start mode.
// RL8 - Start mode 00 never auto starts; 01 starts at transmission end.
// RL9 - Start modes 10 and 11 trim oscillator; 11 allows underflow, 10 not.
// RL10 - Auto-restart set reloads third timer and keeps counting at zero.
// RL11 - Auto-restart clear counts third timer to zero then stops.
// RL12 - Third timer underflow sets its timer underflow flag.
// RL13 - Clock select 00 picks carrier clock, 01 picks subcarrier clock.
// RL14 - Clock select 10 counts timer zero underflows, 11 timer one underflows.
// RL15 - Second timer behaves alike and sets its own underflow flag.
// RL16 - Second timer clock select picks carrier, 212 kHz or sibling underflows.
// RL17 - Reserved control bits 6 and 2 ignore writes and read zero.
// RL18 - With an underflow clock, count drops by one per underflow pulse.
package rct_pkg;
	localparam logic [7:0] ADDR_T2_CONTROL     = 8'h19;
	localparam logic [7:0] ADDR_T2_RELOAD_HIGH = 8'h1a;
	localparam logic [7:0] ADDR_T2_RELOAD_LOW  = 8'h1b;
	localparam logic [7:0] ADDR_T2_COUNT_HIGH  = 8'h1c;
	localparam logic [7:0] ADDR_T2_COUNT_LOW   = 8'h1d;
	localparam logic [7:0] ADDR_T3_CONTROL     = 8'h1e;
	localparam logic [7:0] ADDR_T3_RELOAD_HIGH = 8'h1f;
	localparam logic [7:0] ADDR_T3_RELOAD_LOW  = 8'h20;
	localparam logic [7:0] ADDR_T3_COUNT_HIGH  = 8'h21;
	localparam logic [7:0] ADDR_T3_COUNT_LOW   = 8'h22;
	localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h30;
	localparam logic [7:0] ADDR_IRQ_MASK       = 8'h31;
	localparam int BIT_STOP_RX   = 7;
	localparam int BIT_START_HI  = 5;
	localparam int BIT_START_LO  = 4;
	localparam int BIT_AUTO_RST  = 3;
	localparam int BIT_CLK_HI    = 1;
	localparam int BIT_CLK_LO    = 0;
	localparam logic [7:0] CONTROL_WRITE_MASK = 8'hbb;
	localparam logic [7:0] CONTROL_RESET      = 8'h00;
	localparam logic [7:0] RELOAD_RESET       = 8'h00;
	localparam logic [15:0] COUNT_RESET       = 16'h0000;
	localparam logic [1:0] START_NONE      = 2'h0;
	localparam logic [1:0] START_TX_END    = 2'h1;
	localparam logic [1:0] START_TRIM_NOUF = 2'h2;
	localparam logic [1:0] START_TRIM_UF   = 2'h3;
	localparam logic [1:0] CLK_CARRIER   = 2'h0;
	localparam logic [1:0] CLK_SUBCARR   = 2'h1;
	localparam logic [1:0] CLK_UF_TIMER0 = 2'h2;
	localparam logic [1:0] CLK_UF_TIMER1 = 2'h3;
	localparam int NUM_TIMERS = 2;
	localparam int CLK_HZ     = 200000000;
	localparam int CARRIER_HZ = 13560000;
	localparam int SUBCARR_HZ = 211875;
	localparam int CARRIER_DIV = (CLK_HZ + CARRIER_HZ / 2) / CARRIER_HZ;
	localparam int SUBCARR_DIV = (CLK_HZ + SUBCARR_HZ / 2) / SUBCARR_HZ;
	localparam int DIV_W = 12;
	localparam logic [DIV_W-1:0] CARRIER_LAST = DIV_W'(CARRIER_DIV - 1);
	localparam logic [DIV_W-1:0] SUBCARR_LAST = DIV_W'(SUBCARR_DIV - 1);
	localparam logic [DIV_W-1:0] DIV_ZERO     = 12'h000;
	localparam logic [7:0] READ_ZERO = 8'h00;
	typedef enum logic [1:0] {RCT_IDLE, RCT_RUN, RCT_TRIM_WAIT, RCT_TRIM_RUN} rct_state_e;
endpackage

// file: rct_timers.sv
// Two 16-bit reload countdown timers with byte register port and interrupt.
// Assumes all event inputs are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module rct_timers
	import rct_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rdata,
	input  wire logic       tx_end,
	input  wire logic       rx_first_nibble,
	input  wire logic       rx_end,
	input  wire logic       trim_edge,
	input  wire logic       timer0_underflow,
	input  wire logic       timer1_underflow,
	output logic      [1:0] underflow_pulse,
	output logic      [1:0] running,
	output logic            irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Registers and shared count enables.

	logic [7:0]       control_reg [NUM_TIMERS];
	logic [7:0]       reload_hi_reg [NUM_TIMERS];
	logic [7:0]       reload_lo_reg [NUM_TIMERS];
	logic [15:0]      count_reg [NUM_TIMERS];
	logic [1:0]       status_reg;
	logic [1:0]       mask_reg;
	logic [1:0]       uf_event;
	logic [DIV_W-1:0] carrier_div_reg;
	logic [DIV_W-1:0] subcarr_div_reg;
	logic             carrier_tick;
	logic             subcarr_tick;
	logic             rx_active_reg;

	// Byte write to one timer's register, selected by its two addresses.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] t2, input logic [7:0] t3,
		input int idx);
		hit = (idx == 0) ? (a == t2) : (a == t3);
	endfunction

	// Count enable for a timer from its clock select field.
	function automatic logic count_tick(input logic [1:0] sel, input logic c, input logic s,
		input logic u0, input logic u1);
		case (sel)
			CLK_CARRIER:   count_tick = c; // RL13
			CLK_SUBCARR:   count_tick = s; // RL13
			CLK_UF_TIMER0: count_tick = u0; // RL14 RL18
			default:       count_tick = u1; // RL14 RL18
		endcase
	endfunction

	assign carrier_tick = (carrier_div_reg == DIV_ZERO);
	assign subcarr_tick = (subcarr_div_reg == DIV_ZERO);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			carrier_div_reg <= DIV_ZERO;
		else if (carrier_tick)
			carrier_div_reg <= CARRIER_LAST;
		else
			carrier_div_reg <= carrier_div_reg - 12'h001;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			subcarr_div_reg <= DIV_ZERO;
		else if (subcarr_tick)
			subcarr_div_reg <= SUBCARR_LAST;
		else
			subcarr_div_reg <= subcarr_div_reg - 12'h001;
	end

	// Tracks reception so the readback hazard is visible to software.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rx_active_reg <= 1'b0;
		else if (rx_end)
			rx_active_reg <= 1'b0;
		else if (rx_first_nibble)
			rx_active_reg <= 1'b1; // RL5
	end

	////////////////////////////////////////////////////////////////////////////////
	// Timers; index 0 is the second timer, index 1 the third.

	genvar gi;
	generate
		for (gi = 0; gi < NUM_TIMERS; gi++)
		begin : g_timer
			rct_state_e state_reg;
			logic [1:0] start_mode;
			logic       trim_mode;
			logic       tick;
			logic       start_evt;
			logic       stop_rx;
			logic       at_zero;
			logic [15:0] reload_value;

			assign start_mode   = control_reg[gi][BIT_START_HI:BIT_START_LO];
			assign trim_mode    = start_mode[1]; // RL9
			assign reload_value = {reload_hi_reg[gi], reload_lo_reg[gi]}; // RL1 RL3
			assign tick = count_tick(control_reg[gi][BIT_CLK_HI:BIT_CLK_LO], carrier_tick,
				subcarr_tick, timer0_underflow, timer1_underflow); // RL16
			assign start_evt = (start_mode == START_TX_END) && tx_end; // RL8
			assign stop_rx = control_reg[gi][BIT_STOP_RX] && !trim_mode
				&& rx_first_nibble; // RL6 RL7
			assign at_zero = (count_reg[gi] == COUNT_RESET);
			assign uf_event[gi] = (state_reg == RCT_RUN || state_reg == RCT_TRIM_RUN)
				&& tick && at_zero && !(trim_mode && start_mode == START_TRIM_NOUF);

			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					state_reg <= RCT_IDLE;
				else
				begin
					case (state_reg)
						RCT_IDLE:
							if (trim_mode)
								state_reg <= RCT_TRIM_WAIT; // RL9
							else if (start_evt)
								state_reg <= RCT_RUN; // RL8
						RCT_RUN:
							if (trim_mode)
								state_reg <= RCT_TRIM_WAIT;
							else if (stop_rx)
								state_reg <= RCT_IDLE; // RL6
							else if (tick && at_zero && !control_reg[gi][BIT_AUTO_RST])
								state_reg <= RCT_IDLE; // RL11
						RCT_TRIM_WAIT:
							if (!trim_mode)
								state_reg <= RCT_IDLE;
							else if (trim_edge)
								state_reg <= RCT_TRIM_RUN; // RL9
						RCT_TRIM_RUN:
							if (!trim_mode || trim_edge)
								state_reg <= RCT_IDLE; // RL9
							else if (tick && at_zero && start_mode == START_TRIM_NOUF)
								state_reg <= RCT_IDLE;
						default:
							state_reg <= RCT_IDLE;
					endcase
				end
			end

			// Reload bytes are only sampled at a start or an auto reload at zero, so writes never disturb a count.
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					count_reg[gi] <= COUNT_RESET;
				else if ((state_reg == RCT_IDLE && !trim_mode && start_evt)
					|| (state_reg == RCT_TRIM_WAIT && trim_edge))
					count_reg[gi] <= reload_value; // RL1 RL2 RL3
				else if ((state_reg == RCT_RUN || state_reg == RCT_TRIM_RUN) && tick)
				begin
					if (!at_zero)
						count_reg[gi] <= count_reg[gi] - 16'h0001; // RL18
					else if (control_reg[gi][BIT_AUTO_RST] || start_mode == START_TRIM_UF)
						count_reg[gi] <= reload_value; // RL10
				end
			end

			assign running[gi] = (state_reg == RCT_RUN) || (state_reg == RCT_TRIM_RUN);
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			underflow_pulse <= 2'h0;
		else
			underflow_pulse <= uf_event;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register writes.

	generate
		for (gi = 0; gi < NUM_TIMERS; gi++)
		begin : g_regs
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					control_reg[gi] <= CONTROL_RESET;
				else if (wr_en && hit(addr, ADDR_T2_CONTROL, ADDR_T3_CONTROL, gi))
					control_reg[gi] <= wdata & CONTROL_WRITE_MASK; // RL17
			end

			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					reload_hi_reg[gi] <= RELOAD_RESET;
				else if (wr_en && hit(addr, ADDR_T2_RELOAD_HIGH, ADDR_T3_RELOAD_HIGH, gi))
					reload_hi_reg[gi] <= wdata; // RL3
			end

			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					reload_lo_reg[gi] <= RELOAD_RESET;
				else if (wr_en && hit(addr, ADDR_T2_RELOAD_LOW, ADDR_T3_RELOAD_LOW, gi))
					reload_lo_reg[gi] <= wdata; // RL2 RL3
			end
		end
	endgenerate

	// Flags are sticky; a new underflow wins over a write-one clear.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			status_reg <= 2'h0;
		else if (wr_en && addr == ADDR_IRQ_STATUS)
			status_reg <= (status_reg & ~wdata[1:0]) | uf_event; // RL12 RL15
		else
			status_reg <= status_reg | uf_event; // RL12 RL15
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mask_reg <= 2'h0;
		else if (wr_en && addr == ADDR_IRQ_MASK)
			mask_reg <= wdata[1:0];
	end

	assign irq = |(status_reg & mask_reg);

	////////////////////////////////////////////////////////////////////////////////
	// Register reads, one cycle after the strobe; unmapped addresses read zero.

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= READ_ZERO;
		else if (rd_en)
		begin
			case (addr)
				ADDR_T2_CONTROL:     rdata <= control_reg[0];
				ADDR_T2_RELOAD_HIGH: rdata <= reload_hi_reg[0];
				ADDR_T2_RELOAD_LOW:  rdata <= reload_lo_reg[0];
				ADDR_T2_COUNT_HIGH:  rdata <= count_reg[0][15:8]; // RL4
				ADDR_T2_COUNT_LOW:   rdata <= count_reg[0][7:0]; // RL4
				ADDR_T3_CONTROL:     rdata <= control_reg[1]; // RL17
				ADDR_T3_RELOAD_HIGH: rdata <= reload_hi_reg[1]; // RL3
				ADDR_T3_RELOAD_LOW:  rdata <= reload_lo_reg[1]; // RL3
				ADDR_T3_COUNT_HIGH:  rdata <= count_reg[1][15:8];
				ADDR_T3_COUNT_LOW:   rdata <= count_reg[1][7:0];
				ADDR_IRQ_STATUS:     rdata <= {5'h00, rx_active_reg, status_reg};
				ADDR_IRQ_MASK:       rdata <= {6'h00, mask_reg};
				default:             rdata <= READ_ZERO;
			endcase
		end
		else
			rdata <= READ_ZERO;
	end

endmodule // rct_timers
`default_nettype wire

// file: rct_timers_chk.sv
// Port-level timing checks for the reload countdown timers.
// Assumes it is bound to rct_timers and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rct_timers_chk
	import rct_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [7:0] rdata,
	input wire logic       tx_end,
	input wire logic       rx_first_nibble,
	input wire logic       rx_end,
	input wire logic       trim_edge,
	input wire logic       timer0_underflow,
	input wire logic       timer1_underflow,
	input wire logic [1:0] underflow_pulse,
	input wire logic [1:0] running,
	input wire logic       irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////
	a_rdata_idle: assert property (!$past(rd_en) |-> rdata == READ_ZERO)
		else $error("read data not zero outside a read answer");
	a_t3_rsvd_zero: assert property ($past(rd_en) && $past(addr) == ADDR_T3_CONTROL
		|-> rdata[6] == 1'b0 && rdata[2] == 1'b0) else $error("third control reserved bit set");
	a_t2_rsvd_zero: assert property ($past(rd_en) && $past(addr) == ADDR_T2_CONTROL
		|-> rdata[6] == 1'b0 && rdata[2] == 1'b0) else $error("second control reserved bit set");
	a_unmapped_zero: assert property ($past(rd_en) && $past(addr) == 8'h40
		|-> rdata == READ_ZERO) else $error("unmapped read not zero");
	a_reset_quiet: assert property ($rose(rst_n) |-> running == 2'h0 && !irq)
		else $error("activity right after reset");
	a_t3_start_cause: assert property ($rose(running[1]) |-> $past(tx_end || trim_edge))
		else $error("third timer started without a start event");
	a_t2_start_cause: assert property ($rose(running[0]) |-> $past(tx_end || trim_edge))
		else $error("second timer started without a start event");
	a_t3_uf_running: assert property (underflow_pulse[1]
		|-> $past(running[1]) || $past(running[1], 2)) else $error("third underflow while idle");
	a_t2_uf_running: assert property (underflow_pulse[0]
		|-> $past(running[0]) || $past(running[0], 2)) else $error("second underflow while idle");
	c_t3_uf: cover property (underflow_pulse[1]);
	c_t2_run: cover property ($rose(running[0]));
	c_irq: cover property ($rose(irq));
endmodule // rct_timers_chk
`default_nettype wire

// file: tb_reload_countdown_timers.sv
// Self-checking bench for the reload countdown timers.
// Assumes the register map and event pulses described for rct_timers.
`timescale 1ns/1ps
`default_nettype none
module tb_reload_countdown_timers
	import rct_pkg::*;
;
	logic       clk, rst_n, wr_en, rd_en, irq;
	logic [7:0] addr, wdata, rdata;
	logic [5:0] ev;
	logic [1:0] underflow_pulse, running;
	int         mismatches, num_checks;
	logic [7:0] regs[6] = '{ADDR_T2_RELOAD_LOW, ADDR_T2_COUNT_HIGH, ADDR_T2_COUNT_LOW,
		ADDR_T3_CONTROL, ADDR_T3_RELOAD_HIGH, ADDR_T3_RELOAD_LOW};
	logic [7:0] trims[2] = '{8'ha0, 8'hb0};
	rct_timers dut_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .tx_end(ev[0]), .rx_first_nibble(ev[1]), .rx_end(ev[2]),
		.trim_edge(ev[3]), .timer0_underflow(ev[4]), .timer1_underflow(ev[5]),
		.underflow_pulse(underflow_pulse), .running(running), .irq(irq));
	////////////////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(rdata, e);
		@(posedge clk);
	endtask
	task rd16(input logic [7:0] a, input logic [15:0] e);
		rd(a, e[15:8]);
		rd(a + 8'h01, e[7:0]);
	endtask
	task pulse(input int b, input int n);
		repeat (n)
		begin
			ev[b] <= 1'b1;
			@(posedge clk);
			ev[b] <= 1'b0;
			@(posedge clk);
		end
	endtask
	task pulse_uf(input int b, input logic [1:0] e);
		ev[b] <= 1'b1;
		@(posedge clk);
		ev[b] <= 1'b0;
		#1;
		chk({6'h00, underflow_pulse}, {6'h00, e});
		@(posedge clk);
	endtask
	task rate(input logic [7:0] a, input int per, input int k);
		logic [7:0] v;
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		v = rdata;
		repeat (per * k - 1) @(posedge clk);
		rd(a, v - 8'(k));
	endtask
	task run(input logic [1:0] e);
		#1;
		chk({6'h00, running}, {6'h00, e});
	endtask
	task stop_test;
		$display("checks %0d, mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		stop_test;
	end
	initial
	begin
		rst_n = 1'b0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		ev = 6'h00;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (regs[i]) rd(regs[i], 8'h00);
		wr(ADDR_T3_CONTROL, 8'hff);
		rd(ADDR_T3_CONTROL, 8'hbb);
		wr(ADDR_T2_CONTROL, 8'hff);
		rd(ADDR_T2_CONTROL, 8'hbb);
		wr(ADDR_T2_CONTROL, 8'h00);
		wr(ADDR_T2_COUNT_HIGH, 8'hff);
		rd(ADDR_T2_COUNT_HIGH, 8'h00);
		rd(8'h40, 8'h00);
		wr(ADDR_T3_RELOAD_HIGH, 8'ha5);
		rd(ADDR_T3_RELOAD_HIGH, 8'ha5);
		$display("test registers done");
		wr(ADDR_T3_RELOAD_HIGH, 8'h00);
		wr(ADDR_T3_RELOAD_LOW, 8'h03);
		wr(ADDR_T3_CONTROL, 8'h12);
		pulse(0, 1);
		run(2'b10);
		rd16(ADDR_T3_COUNT_HIGH, 16'h0003);
		pulse(4, 1);
		rd16(ADDR_T3_COUNT_HIGH, 16'h0002);
		wr(ADDR_T3_RELOAD_LOW, 8'h01);
		rd16(ADDR_T3_COUNT_HIGH, 16'h0002);
		pulse(1, 1);
		pulse(2, 1);
		run(2'b10);
		pulse(4, 2);
		pulse_uf(4, 2'b10);
		run(2'b00);
		rd(ADDR_IRQ_STATUS, 8'h02);
		wr(ADDR_IRQ_MASK, 8'h03);
		run(2'b00);
		chk({7'h00, irq}, 8'h01);
		wr(ADDR_IRQ_STATUS, 8'h02);
		#1;
		chk({7'h00, irq}, 8'h00);
		$display("test one shot done");
		wr(ADDR_T3_CONTROL, 8'h9b);
		pulse(0, 1);
		pulse(5, 1);
		pulse_uf(5, 2'b10);
		run(2'b10);
		rd16(ADDR_T3_COUNT_HIGH, 16'h0001);
		pulse(1, 1);
		run(2'b00);
		pulse(2, 1);
		rd(ADDR_IRQ_STATUS, 8'h02);
		wr(ADDR_IRQ_STATUS, 8'h02);
		$display("test restart done");
		wr(ADDR_T3_RELOAD_HIGH, 8'h10);
		foreach (trims[i])
		begin
			wr(ADDR_T3_CONTROL, trims[i]);
			pulse(3, 1);
			run(2'b10);
			rate(ADDR_T3_COUNT_LOW, CARRIER_DIV, 2);
			pulse(1, 1);
			pulse(2, 1);
			run(2'b10);
			pulse(3, 1);
			run(2'b00);
		end
		wr(ADDR_T3_RELOAD_HIGH, 8'h00);
		wr(ADDR_T3_CONTROL, 8'hb2);
		pulse(3, 1);
		pulse(4, 1);
		pulse_uf(4, 2'b10);
		run(2'b10);
		rd(ADDR_IRQ_STATUS, 8'h02);
		wr(ADDR_IRQ_STATUS, 8'h02);
		pulse(3, 1);
		run(2'b00);
		wr(ADDR_T3_CONTROL, 8'h00);
		pulse(0, 1);
		pulse(3, 1);
		run(2'b00);
		$display("test modes done");
		wr(ADDR_T2_RELOAD_HIGH, 8'h00);
		wr(ADDR_T2_RELOAD_LOW, 8'h01);
		wr(ADDR_T2_CONTROL, 8'h12);
		pulse(0, 1);
		run(2'b01);
		rd16(ADDR_T2_COUNT_HIGH, 16'h0001);
		pulse(4, 1);
		pulse_uf(4, 2'b01);
		run(2'b00);
		rd(ADDR_IRQ_STATUS, 8'h01);
		$display("test second timer done");
		wr(ADDR_T2_RELOAD_LOW, 8'hf0);
		wr(ADDR_T2_CONTROL, 8'h10);
		pulse(0, 1);
		rate(ADDR_T2_COUNT_LOW, CARRIER_DIV, 4);
		wr(ADDR_T3_RELOAD_HIGH, 8'h10);
		wr(ADDR_T3_CONTROL, 8'h11);
		pulse(0, 1);
		rate(ADDR_T3_COUNT_LOW, SUBCARR_DIV, 2);
		$display("test rates done");
		stop_test;
	end
endmodule // tb_reload_countdown_timers
bind rct_timers rct_timers_chk chk_u (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
	.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .tx_end(tx_end),
	.rx_first_nibble(rx_first_nibble), .rx_end(rx_end), .trim_edge(trim_edge),
	.timer0_underflow(timer0_underflow), .timer1_underflow(timer1_underflow),
	.underflow_pulse(underflow_pulse), .running(running), .irq(irq));
`default_nettype wire
